// ==== hw/ctpsc_top.sv ====
`timescale 1ns/1ps
`include "ctpsc_consts.svh"
module ctpsc_top #(
   parameter int STARTUP_CYCLES = `CTPSC_STARTUP_CYCLES
) (
   input wire logic I_CORE_CLK,
   input wire logic I_RST_N,
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [11:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   output logic [31:0] O_PRDATA,
   output logic O_PREADY,
   output logic O_PSLVERR,
   input wire logic [7:0] I_FACTORY_TRIM,
   input wire logic I_FUSE_DIV8,
   input wire logic I_FUSE_XTAL,
   input wire logic I_SLEEP_EXEC,
   input wire logic I_ADC_ENABLED,
   input wire logic I_IRQ_ANY,
   input wire logic I_ADC_DONE,
   input wire logic I_EXT_INT_ZERO,
   input wire logic I_PIN_CHANGE,
   input wire logic I_NVM_READY,
   input wire logic I_WDT_IRQ,
   output logic [7:0] O_OSC_TRIM,
   output logic O_TRIM_HIGH_RANGE,
   output logic O_SYS_TICK,
   output logic O_CPU_CLK_EN,
   output logic O_FLASH_CLK_EN,
   output logic O_IO_CLK_EN,
   output logic O_ADC_CLK_EN,
   output logic O_OSC_EN,
   output logic O_ADC_START,
   output logic O_WAKE_IRQ
);
   localparam int NWAKE = 6;
   localparam logic [15:0] STARTUP_CNT = 16'(STARTUP_CYCLES);

   ctpsc_div_if div_bus ();

   logic strap_done;
   logic [7:0] trim;
   logic unlock;
   logic [1:0] unlock_cnt;
   logic [3:0] sel;
   logic arm;
   logic [1:0] kind;
   logic [NWAKE-1:0] wake_meta;
   logic [NWAKE-1:0] wake_sync;
   ctpsc_pkg::ctpsc_state_t state;
   ctpsc_pkg::ctpsc_state_t next_state;
   logic [15:0] wake_cnt;
   logic [15:0] next_wake_cnt;
   logic setup;
   logic access;
   logic wr;
   ctpsc_pkg::ctpsc_reg_t rsel;
   ctpsc_pkg::ctpsc_reg_t wsel;
   logic [7:0] rmux;
   logic [7:0] wbyte;
   logic irq_w;
   logic adc_w;
   logic ext_zero_w;
   logic pinc_w;
   logic nvm_w;
   logic wdt_w;
   logic wake_hit;
   logic enter;

   // byte address to register
   function automatic ctpsc_pkg::ctpsc_reg_t decode(input logic [11:0] a);
      ctpsc_pkg::ctpsc_reg_t r;
      r = ctpsc_pkg::CTPSC_R_NONE;
      if (a[1:0] == 2'h0 && a[11:10] == 2'h0) begin
         unique case (a[9:2])
            `CTPSC_IDX_TRIM: r = ctpsc_pkg::CTPSC_R_TRIM;
            `CTPSC_IDX_DIV: r = ctpsc_pkg::CTPSC_R_DIV;
            `CTPSC_IDX_MCU: r = ctpsc_pkg::CTPSC_R_MCU;
            `CTPSC_IDX_STAT: r = ctpsc_pkg::CTPSC_R_STAT;
            default: r = ctpsc_pkg::CTPSC_R_NONE;
         endcase
      end
      return r;
   endfunction : decode

   // apb handshake, zero wait states
   assign setup = I_PSEL & ~I_PENABLE;
   assign access = I_PSEL & I_PENABLE & O_PREADY;
   assign rsel = decode(I_PADDR);
   assign wsel = rsel;
   assign wr = access & I_PWRITE & (wsel != ctpsc_pkg::CTPSC_R_NONE);
   assign wbyte = I_PWDATA[7:0];

   always_comb begin
      rmux = 8'h00;
      unique case (rsel)
         ctpsc_pkg::CTPSC_R_TRIM: rmux = trim;
         ctpsc_pkg::CTPSC_R_DIV: rmux = {unlock, 3'h0, sel};
         ctpsc_pkg::CTPSC_R_MCU: rmux = {2'h0, arm, kind, 3'h0};
         ctpsc_pkg::CTPSC_R_STAT: rmux = {wake_sync[5:4], 3'h0, state};
         default: rmux = 8'h00;
      endcase
   end

   always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_PREADY <= 1'b0;
      end else begin
         O_PREADY <= setup;
      end
   end

   always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_PRDATA <= 32'h0000_0000;
         O_PSLVERR <= 1'b0;
      end else if (setup) begin
         O_PRDATA <= I_PWRITE ? 32'h0000_0000 : {24'h00_0000, rmux};
         O_PSLVERR <= (rsel == ctpsc_pkg::CTPSC_R_NONE);
      end else if (!I_PSEL) begin
         O_PSLVERR <= 1'b0;
      end
   end

   // factory trim and divide-by-eight fuse caught once after reset release
   always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         strap_done <= 1'b0;
      end else begin
         strap_done <= 1'b1;
      end
   end

   // oscillator trim
   always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         trim <= 8'h00;
      end else if (!strap_done) begin
         trim <= I_FACTORY_TRIM;
      end else if (wr && wsel == ctpsc_pkg::CTPSC_R_TRIM) begin
         trim <= wbyte;
      end
   end

   always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_OSC_TRIM <= 8'h00;
         O_TRIM_HIGH_RANGE <= 1'b0;
      end else begin
         O_OSC_TRIM <= trim;
         O_TRIM_HIGH_RANGE <= trim[`CTPSC_TRIM_RANGE_BIT];
      end
   end

   // divider unlock window
   always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         unlock <= 1'b0;
         unlock_cnt <= 2'h0;
      end else if (wr && wsel == ctpsc_pkg::CTPSC_R_DIV
                   && wbyte[`CTPSC_DIV_UNLOCK_BIT] && !unlock
                   && wbyte[6:0] == 7'h00) begin
         unlock <= 1'b1;
         unlock_cnt <= 2'h0;
      end else if (unlock) begin
         if (wr && wsel == ctpsc_pkg::CTPSC_R_DIV
             && !wbyte[`CTPSC_DIV_UNLOCK_BIT]) begin
            unlock <= 1'b0;
         end else if (unlock_cnt == `CTPSC_UNLOCK_LAST) begin
            unlock <= 1'b0;
         end else begin
            unlock_cnt <= unlock_cnt + 2'h1;
         end
      end
   end

   // divider select
   always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         sel <= `CTPSC_SEL_DIV1;
      end else if (!strap_done) begin
         sel <= I_FUSE_DIV8 ? `CTPSC_SEL_DIV8 : `CTPSC_SEL_DIV1;
      end else if (wr && wsel == ctpsc_pkg::CTPSC_R_DIV && unlock
                   && !wbyte[`CTPSC_DIV_UNLOCK_BIT]) begin
         sel <= wbyte[`CTPSC_DIV_SEL_MSB:0];
      end
   end

   assign div_bus.sel = sel;

   ctpsc_prescaler u_presc (
      .i_clk(I_CORE_CLK),
      .i_rst_n(I_RST_N),
      .div(div_bus)
   );

   always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_SYS_TICK <= 1'b0;
      end else begin
         O_SYS_TICK <= div_bus.tick;
      end
   end

   // mcu control: arm and kind
   always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         arm <= 1'b0;
         kind <= 2'h0;
      end else if (wr && wsel == ctpsc_pkg::CTPSC_R_MCU) begin
         arm <= wbyte[`CTPSC_MCU_ARM_BIT];
         kind <= wbyte[`CTPSC_MCU_KIND_MSB:`CTPSC_MCU_KIND_LSB];
      end
   end

   // wake inputs from pins, two-flop synchroniser
   generate
      for (genvar g = 0; g < NWAKE; g++) begin : g_sync
         always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
            if (!I_RST_N) begin
               wake_meta[g] <= 1'b0;
               wake_sync[g] <= 1'b0;
            end else begin
               wake_meta[g] <= (g == 0) ? I_IRQ_ANY :
                               (g == 1) ? I_ADC_DONE :
                               (g == 2) ? I_NVM_READY :
                               (g == 3) ? I_WDT_IRQ :
                               (g == 4) ? I_EXT_INT_ZERO : I_PIN_CHANGE;
               wake_sync[g] <= wake_meta[g];
            end
         end
      end
   endgenerate

   assign irq_w = wake_sync[0];
   assign adc_w = wake_sync[1];
   assign nvm_w = wake_sync[2];
   assign wdt_w = wake_sync[3];
   assign ext_zero_w = wake_sync[4];
   assign pinc_w = wake_sync[5];

   assign enter = I_SLEEP_EXEC & arm;

   // sleep state machine
   always_comb begin
      next_state = state;
      next_wake_cnt = wake_cnt;
      wake_hit = 1'b0;
      unique case (state)
         ctpsc_pkg::CTPSC_RUN: begin
            if (enter) begin
               unique case (ctpsc_pkg::ctpsc_kind_t'(kind))
                  ctpsc_pkg::CTPSC_K_IDLE:
                     next_state = ctpsc_pkg::CTPSC_IDLE;
                  ctpsc_pkg::CTPSC_K_ADCNR:
                     next_state = ctpsc_pkg::CTPSC_ADCNR;
                  ctpsc_pkg::CTPSC_K_PDOWN:
                     next_state = ctpsc_pkg::CTPSC_PDOWN;
                  ctpsc_pkg::CTPSC_K_STBY:
                     if (I_FUSE_XTAL) begin
                        next_state = ctpsc_pkg::CTPSC_STBY;
                     end
               endcase
            end
         end
         ctpsc_pkg::CTPSC_IDLE: begin
            wake_hit = irq_w;
            next_wake_cnt = `CTPSC_WAKE_HALT;
         end
         ctpsc_pkg::CTPSC_ADCNR: begin
            wake_hit = adc_w | nvm_w | wdt_w | ext_zero_w | pinc_w;
            next_wake_cnt = `CTPSC_WAKE_HALT;
         end
         ctpsc_pkg::CTPSC_PDOWN: begin
            wake_hit = wdt_w | ext_zero_w | pinc_w;
            next_wake_cnt = STARTUP_CNT + `CTPSC_WAKE_HALT;
         end
         ctpsc_pkg::CTPSC_STBY: begin
            wake_hit = wdt_w | ext_zero_w | pinc_w;
            next_wake_cnt = `CTPSC_STBY_WAKE;
         end
         ctpsc_pkg::CTPSC_WAKE: begin
            next_wake_cnt = wake_cnt - 16'h0001;
            if (wake_cnt == 16'h0001) begin
               next_state = ctpsc_pkg::CTPSC_RUN;
            end
         end
         default: begin
            next_state = ctpsc_pkg::CTPSC_RUN;
         end
      endcase
      if (wake_hit) begin
         next_state = ctpsc_pkg::CTPSC_WAKE;
      end
   end

   always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         state <= ctpsc_pkg::CTPSC_RUN;
         wake_cnt <= 16'h0000;
      end else begin
         state <= next_state;
         wake_cnt <= next_wake_cnt;
      end
   end

   // clock domain gates per state
   always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_CPU_CLK_EN <= 1'b1;
         O_FLASH_CLK_EN <= 1'b1;
         O_IO_CLK_EN <= 1'b1;
         O_ADC_CLK_EN <= 1'b1;
         O_OSC_EN <= 1'b1;
      end else begin
         O_CPU_CLK_EN <= (next_state == ctpsc_pkg::CTPSC_RUN);
         O_FLASH_CLK_EN <= (next_state == ctpsc_pkg::CTPSC_RUN);
         O_IO_CLK_EN <= (next_state == ctpsc_pkg::CTPSC_RUN)
                     || (next_state == ctpsc_pkg::CTPSC_IDLE)
                     || (next_state == ctpsc_pkg::CTPSC_WAKE);
         O_ADC_CLK_EN <= (next_state == ctpsc_pkg::CTPSC_RUN)
                      || (next_state == ctpsc_pkg::CTPSC_IDLE)
                      || (next_state == ctpsc_pkg::CTPSC_ADCNR)
                      || (next_state == ctpsc_pkg::CTPSC_WAKE);
         O_OSC_EN <= (next_state != ctpsc_pkg::CTPSC_PDOWN);
      end
   end

   // adc start on entry and resume pulse
   always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_ADC_START <= 1'b0;
         O_WAKE_IRQ <= 1'b0;
      end else begin
         O_ADC_START <= (state == ctpsc_pkg::CTPSC_RUN) && I_ADC_ENABLED
                     && ((next_state == ctpsc_pkg::CTPSC_IDLE)
                     || (next_state == ctpsc_pkg::CTPSC_ADCNR));
         O_WAKE_IRQ <= (state == ctpsc_pkg::CTPSC_WAKE)
                    && (next_state == ctpsc_pkg::CTPSC_RUN);
      end
   end
endmodule : ctpsc_top

// ==== inc/ctpsc_consts.svh ====
// Behaviour
// - each reset loads the oscillator trim from the factory value
// - trim top bit picks low or high oscillator range
// - trim low seven bits tune frequency upward within the range
// - unlock bit sets only when all other divider bits are written zero
// - unlock clears four cycles after setting, or when select is written
// - rewriting unlock in its window neither restarts nor clears it
// - divider bits 6 to 4 always read zero
// - select changes only if written with unlock zero inside the window
// - select resets to 0000, or 0011 when divide-by-eight fuse is set
// - select accepts any written value whatever the fuse says
// - codes 0000 to 1000 divide by 1 to 256, others reserved
// - divided clock drives the system clock and may change at run time
// - sleep starts only with arm bit set and a sleep instruction
// - kind 00 idle stops cpu and flash, any interrupt wakes
// - kind 01 stops io, cpu, flash; limited wake sources
// - kind 10 stops oscillator and all clocks; fewest wake sources
// - interrupt wake halts four cycles, start-up plus four from power-down, then resumes
// - any reset during sleep restarts from the reset vector
// - idle or adc sleep with adc enabled starts a conversion
// - kind 11 with crystal is standby, oscillator on, six-cycle wake
// - arm bit 5, kind bits 4:3 at index 0x35, reset zero
// - divider change is glitch-free and never faster than either setting
`ifndef CTPSC_CONSTS_SVH
`define CTPSC_CONSTS_SVH
`define CTPSC_IDX_TRIM 8'h31
`define CTPSC_IDX_DIV 8'h32
`define CTPSC_IDX_MCU 8'h35
`define CTPSC_IDX_STAT 8'h3a
`define CTPSC_TRIM_RANGE_BIT 7
`define CTPSC_DIV_UNLOCK_BIT 7
`define CTPSC_DIV_SEL_MSB 3
`define CTPSC_MCU_ARM_BIT 5
`define CTPSC_MCU_KIND_MSB 4
`define CTPSC_MCU_KIND_LSB 3
`define CTPSC_SEL_DIV1 4'h0
`define CTPSC_SEL_DIV8 4'h3
`define CTPSC_SEL_MAX 4'h8
`define CTPSC_UNLOCK_LAST 2'h3
`define CTPSC_WAKE_HALT 16'h0004
`define CTPSC_STBY_WAKE 16'h0006
`define CTPSC_STARTUP_CYCLES 16
`endif

// ==== inc/ctpsc_pkg.sv ====
package ctpsc_pkg;
   typedef enum logic [2:0] {
      CTPSC_RUN = 3'b000,
      CTPSC_IDLE = 3'b001,
      CTPSC_ADCNR = 3'b010,
      CTPSC_PDOWN = 3'b011,
      CTPSC_STBY = 3'b100,
      CTPSC_WAKE = 3'b101
   } ctpsc_state_t;
   typedef enum logic [1:0] {
      CTPSC_K_IDLE = 2'b00,
      CTPSC_K_ADCNR = 2'b01,
      CTPSC_K_PDOWN = 2'b10,
      CTPSC_K_STBY = 2'b11
   } ctpsc_kind_t;
   typedef enum logic [2:0] {
      CTPSC_R_NONE = 3'b000,
      CTPSC_R_TRIM = 3'b001,
      CTPSC_R_DIV = 3'b010,
      CTPSC_R_MCU = 3'b011,
      CTPSC_R_STAT = 3'b100
   } ctpsc_reg_t;
endpackage : ctpsc_pkg

// ==== inc/ctpsc_div_if.sv ====
`timescale 1ns/1ps
interface ctpsc_div_if;
   logic [3:0] sel;
   logic tick;
   modport ctrl (output sel, input tick);
   modport presc (input sel, output tick);
endinterface : ctpsc_div_if

// ==== hw/ctpsc_prescaler.sv ====
`timescale 1ns/1ps
`include "ctpsc_consts.svh"
module ctpsc_prescaler (
   input wire logic i_clk,
   input wire logic i_rst_n,
   ctpsc_div_if.presc div
);
   logic [7:0] cnt;
   logic [7:0] term;
   logic [7:0] next_term;

   // select code to terminal count
   function automatic logic [7:0] sel_term(input logic [3:0] s);
      logic [7:0] t;
      t = 8'hff;
      if (s <= `CTPSC_SEL_MAX) begin
         t = 8'((9'h001 << s) - 9'h001);
      end
      return t;
   endfunction : sel_term

   assign next_term = sel_term(div.sel);

   // new ratio only at the end of a running period
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt <= 8'h00;
         term <= 8'h00;
      end else if (cnt >= term) begin
         cnt <= 8'h00;
         term <= next_term;
      end else begin
         cnt <= cnt + 8'h01;
      end
   end

   // one pulse per system clock period
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         div.tick <= 1'b0;
      end else begin
         div.tick <= (cnt >= term);
      end
   end
endmodule : ctpsc_prescaler

// ==== testbench/ctpsc_top_chk.sv ====
`timescale 1ns/1ps
module ctpsc_top_chk (
   input wire logic I_CORE_CLK,
   input wire logic I_RST_N,
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_SLEEP_EXEC,
   input wire logic O_PREADY,
   input wire logic [7:0] O_OSC_TRIM,
   input wire logic O_TRIM_HIGH_RANGE,
   input wire logic O_CPU_CLK_EN,
   input wire logic O_FLASH_CLK_EN,
   input wire logic O_IO_CLK_EN,
   input wire logic O_ADC_CLK_EN,
   input wire logic O_OSC_EN,
   input wire logic O_ADC_START,
   input wire logic O_WAKE_IRQ
);
   default clocking @(posedge I_CORE_CLK); endclocking
   default disable iff (!I_RST_N);
   sequence s_setup;
      I_PSEL && !I_PENABLE;
   endsequence
   sequence s_resume;
      O_WAKE_IRQ ##[0:1] O_CPU_CLK_EN;
   endsequence
   a_ready_setup: assert property (s_setup |=> O_PREADY)
      else $error("ready missing after setup");
   a_ready_pulse: assert property (O_PREADY |=> !O_PREADY)
      else $error("ready longer than one cycle");
   a_range_bit: assert property (
      O_TRIM_HIGH_RANGE == O_OSC_TRIM[7])
      else $error("range bit differs from trim top bit");
   a_sleep_cause: assert property (
      $fell(O_CPU_CLK_EN) |-> $past(I_SLEEP_EXEC))
      else $error("cpu clock stopped without sleep instruction");
   a_idle_domains: assert property (
      !O_CPU_CLK_EN && O_IO_CLK_EN |->
      !O_FLASH_CLK_EN && O_ADC_CLK_EN && O_OSC_EN)
      else $error("idle domains wrong");
   a_adcnr_domains: assert property (
      !O_IO_CLK_EN && O_ADC_CLK_EN |->
      !O_CPU_CLK_EN && !O_FLASH_CLK_EN && O_OSC_EN)
      else $error("adc sleep domains wrong");
   a_pdown_domains: assert property (
      !O_OSC_EN |-> !O_CPU_CLK_EN && !O_IO_CLK_EN && !O_ADC_CLK_EN)
      else $error("clock running with oscillator off");
   a_adc_start: assert property (
      O_ADC_START |-> !O_CPU_CLK_EN && O_ADC_CLK_EN)
      else $error("adc start outside sleep");
   a_wake_resume: assert property (O_WAKE_IRQ |-> s_resume)
      else $error("cpu not resumed on wake");
   a_wake_halt: assert property (
      O_WAKE_IRQ |-> $past(!O_CPU_CLK_EN, 4))
      else $error("cpu resumed without wake halt");
endmodule : ctpsc_top_chk

bind ctpsc_top ctpsc_top_chk u_chk (.I_CORE_CLK, .I_RST_N, .I_PSEL,
   .I_PENABLE, .I_SLEEP_EXEC, .O_PREADY, .O_OSC_TRIM, .O_TRIM_HIGH_RANGE,
   .O_CPU_CLK_EN, .O_FLASH_CLK_EN, .O_IO_CLK_EN, .O_ADC_CLK_EN, .O_OSC_EN,
   .O_ADC_START, .O_WAKE_IRQ);

// ==== testbench/ctpsc_tb_top.sv ====
`timescale 1ns/1ps
module ctpsc_tb_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rdata;
   logic [7:0] ftrim = 8'ha5, trim;
   logic fuse8 = 1'b0, xtal = 1'b1, exec = 1'b0, adc_on = 1'b1;
   logic [5:0] wk = 6'h00;
   logic err;
   logic pready, pslverr, hi, tick, cpu, fl, io, adc, osc, adc_st, wake;
   int n_fail = 0, num_checks = 0, n_start = 0, n_wake = 0;
   always #2.5 clk = ~clk;
   ctpsc_top #(.STARTUP_CYCLES(2)) dut (.I_CORE_CLK(clk), .I_RST_N(rst_n),
      .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
      .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
      .O_PREADY(pready), .O_PSLVERR(pslverr), .I_FACTORY_TRIM(ftrim),
      .I_FUSE_DIV8(fuse8), .I_FUSE_XTAL(xtal), .I_SLEEP_EXEC(exec),
      .I_ADC_ENABLED(adc_on), .I_IRQ_ANY(wk[0]), .I_ADC_DONE(wk[1]),
      .I_EXT_INT_ZERO(wk[4]), .I_PIN_CHANGE(wk[5]), .I_NVM_READY(wk[2]),
      .I_WDT_IRQ(wk[3]), .O_OSC_TRIM(trim), .O_TRIM_HIGH_RANGE(hi),
      .O_SYS_TICK(tick), .O_CPU_CLK_EN(cpu), .O_FLASH_CLK_EN(fl),
      .O_IO_CLK_EN(io), .O_ADC_CLK_EN(adc), .O_OSC_EN(osc),
      .O_ADC_START(adc_st), .O_WAKE_IRQ(wake));
   always @(posedge clk) begin
      if (adc_st === 1'b1) n_start++;
      if (wake === 1'b1) n_wake++;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] idx,
         input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rdata = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic do_reset(input logic f8, input logic [7:0] ft);
      rst_n <= 1'b0;
      fuse8 <= f8;
      ftrim <= ft;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      chk(trim, ft);
      chk(hi, ft[7]);
      apb(1'b0, 8'h32, 32'h0);
      chk(rdata, f8 ? 32'h3 : 32'h0);
      $display("reset test done");
   endtask : do_reset
   task automatic t_regs;
      apb(1'b1, 8'h31, 32'hffff_ff85);
      apb(1'b1, 8'h31, 32'hffff_ff7f);
      apb(1'b0, 8'h31, 32'h0);
      chk(rdata, 32'h7f);
      chk(hi, 1'b0);
      apb(1'b1, 8'h31, 32'h80);
      repeat (2) @(posedge clk);
      chk(hi, 1'b1);
      chk(trim, 8'h80);
      apb(1'b0, 8'h00, 32'h0);
      chk(err, 1'b1);
      chk(rdata, 32'h0);
      $display("register test done");
   endtask : t_regs
   task automatic period(input int exp);
      int n;
      repeat (2) @(posedge clk iff tick === 1'b1);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (tick !== 1'b1);
      chk(n, exp);
   endtask : period
   task automatic t_div;
      for (int c = 0; c < 16; c++) begin
         apb(1'b1, 8'h32, 32'h80);
         apb(1'b1, 8'h32, c);
         apb(1'b0, 8'h32, 32'h0);
         chk(rdata, c);
         period(c > 8 ? 256 : 1 << c);
      end
      apb(1'b1, 8'h32, 32'h81);
      apb(1'b1, 8'h32, 32'h02);
      apb(1'b0, 8'h32, 32'h0);
      chk(rdata, 32'h0f);
      apb(1'b1, 8'h32, 32'h80);
      apb(1'b0, 8'h32, 32'h0);
      chk(rdata, 32'h8f);
      apb(1'b0, 8'h32, 32'h0);
      chk(rdata, 32'h0f);
      apb(1'b1, 8'h32, 32'h80);
      apb(1'b1, 8'h32, 32'h80);
      apb(1'b1, 8'h32, 32'h72);
      apb(1'b0, 8'h32, 32'h0);
      chk(rdata, 32'h0f);
      apb(1'b1, 8'h32, 32'h80);
      apb(1'b1, 8'h32, 32'h72);
      apb(1'b0, 8'h32, 32'h0);
      chk(rdata, 32'h02);
      $display("divider test done");
   endtask : t_div
   task automatic sleep_cmd(input logic [7:0] m);
      apb(1'b1, 8'h35, m);
      apb(1'b0, 8'h35, 32'h0);
      chk(rdata, m & 8'h38);
      exec <= 1'b1;
      @(posedge clk);
      exec <= 1'b0;
      repeat (2) @(posedge clk);
   endtask : sleep_cmd
   task automatic t_sleep;
      logic [4:0] en_tab [4] = '{5'b00111, 5'b00011, 5'b00000, 5'b00001};
      logic [1:0] kd [6] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h3, 2'h2};
      logic [5:0] no_tab [4] = '{6'h00, 6'h01, 6'h07, 6'h07};
      int s0, w0;
      sleep_cmd(8'h10);
      chk(cpu, 1'b1);
      for (int k = 0; k < 6; k++) begin
         s0 = n_start;
         w0 = n_wake;
         adc_on <= (k != 2);
         sleep_cmd({3'h1, kd[k], 3'h0});
         chk({cpu, fl, io, adc, osc}, en_tab[kd[k]]);
         chk(n_start, (kd[k] < 2'h2 && k != 2) ? s0 + 1 : s0);
         apb(1'b0, 8'h3a, 32'h0);
         chk(rdata, {29'h0, 3'(kd[k]) + 3'h1});
         if (kd[k] != 2'h0) begin
            wk <= no_tab[kd[k]];
            repeat (20) @(posedge clk);
            chk(cpu, 1'b0);
         end
         wk <= wk | (6'h01 << k);
         while (n_wake == w0) @(posedge clk);
         chk(cpu, 1'b1);
         wk <= 6'h00;
         repeat (4) @(posedge clk);
      end
      xtal <= 1'b0;
      sleep_cmd(8'h38);
      chk(cpu, 1'b1);
      xtal <= 1'b1;
      sleep_cmd(8'h30);
      do_reset(1'b1, 8'h3c);
      chk({cpu, fl, io, adc, osc}, 5'b11111);
      $display("sleep test done");
   endtask : t_sleep
   task report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : report_and_stop
   initial begin
      repeat (40000) @(posedge clk);
      n_fail++;
      report_and_stop();
   end
   initial begin
      do_reset(1'b0, 8'ha5);
      t_regs();
      t_div();
      t_sleep();
      report_and_stop();
   end
endmodule : ctpsc_tb_top
